// *** hw/host_command_front_end.sv ***
// Purpose: Settles network port defaults and parses host command strings.
// Assumes: Host bytes come from a receiver on mclk_i; switches are pins.
// Notes:   Error replies are sent as bytes or as hex characters by protocol.
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module host_command_front_end
(
	input  wire logic                               mclk_i,
	input  wire logic                               reset_n_i,
	input  wire logic                               term_proto_i,
	input  wire logic [7:0]                         switch_bank1_i,
	input  wire logic [7:0]                         switch_bank2_i,
	input  wire host_front_pkg::stream_byte_type    host_byte_i,
	output logic                                    host_ready_o,
	output host_front_pkg::stream_byte_type         resp_byte_o,
	input  wire logic                               resp_ready_i,
	output host_front_pkg::cmd_type                 cmd_o,
	output host_front_pkg::port_setting_type        local_port_o,
	output host_front_pkg::port_setting_type        modem_port_o,
	output logic [15:0]                             host_port_cfg_o,
	input  wire logic [7:0]                         reg_addr_i,
	input  wire logic [31:0]                        reg_wdata_i,
	input  wire logic                               reg_wr_i,
	input  wire logic                               reg_rd_i,
	output logic [31:0]                             reg_rdata_o,
	output logic                                    irq_o
);
	import host_front_pkg::*;

	typedef struct packed {
		logic [16:0]      sync_m;
		logic [16:0]      sync_s;
		logic             host_cfg;
		logic             nm_cfg;
		logic             eha_mode;
		logic             loc_expl;
		logic             mod_expl;
		port_setting_type local_set;
		port_setting_type modem_set;
		logic [2:0]       count;
		logic [7:0]       code;
		logic [7:0]       p1;
		logic [7:0]       p2;
		logic [3:0]       nib_hi;
		logic             nib_half;
		logic             bad;
		tx_state_type     tx_state;
		logic [31:0]      tx_buf;
		logic [2:0]       tx_len;
		logic [2:0]       tx_idx;
		logic             tx_nib;
		logic             tx_ascii;
		stream_byte_type  resp;
		cmd_type          cmd;
		logic [15:0]      last_err;
		logic [EV_W-1:0]  status;
		logic [EV_W-1:0]  mask;
		logic [31:0]      rdata;
	} state_type;

	state_type r_q;
	state_type r_d;

	// Hex character to nibble, flags characters that are not hex digits
	function automatic logic [4:0] hex_value(input logic [7:0] c);
		logic [7:0] v;
		v = 8'h00;
		if (c >= ASCII_ZERO && c <= ASCII_NINE)
			v = c - ASCII_ZERO;
		else if (c >= ASCII_UP_A && c <= ASCII_UP_F)
			v = c - ASCII_UP_A + ASCII_HEX10;
		else if (c >= ASCII_LO_A && c <= ASCII_LO_F)
			v = c - ASCII_LO_A + ASCII_HEX10;
		else
			return 5'h10;
		return {1'b0, v[3:0]};
	endfunction

	// Nibble to upper-case hex character
	function automatic logic [7:0] hex_char(input logic [3:0] n);
		logic [7:0] w;
		w = {4'h0, n};
		if (n < 4'hA)
			return ASCII_ZERO + w;
		return ASCII_UP_A + w - ASCII_HEX10;
	endfunction

	// Rate code from positions 5 to 8, bank bit 0 is position 1
	function automatic logic [3:0] switch_rate(input logic [7:0] sw);
		logic [3:0] c;
		c = {sw[SW_RATE_3], sw[SW_RATE_2], sw[SW_RATE_1], sw[SW_RATE_0]};
		return (c < RATE_MIN) ? RATE_9600 : c;
	endfunction

	// Next-state logic of the whole block
	always_comb
	begin
		logic        proto_t;
		logic [7:0]  bank1;
		logic        take;
		logic        got_byte;
		logic [7:0]  byte_val;
		logic [4:0]  hv;
		logic        ended;
		logic        both_cfg;
		logic [15:0] err;
		logic        with_addr;
		logic [7:0]  out_byte;
		logic [EV_W-1:0] ev;
		proto_t   = 1'b0;
		bank1     = 8'h00;
		take      = 1'b0;
		got_byte  = 1'b0;
		byte_val  = 8'h00;
		hv        = 5'h00;
		ended     = 1'b0;
		both_cfg  = 1'b0;
		err       = 16'h0000;
		with_addr = 1'b0;
		out_byte  = 8'h00;
		ev        = '0;
		r_d       = r_q;

		// Two-stage synchronisers for the protocol strap and switch banks
		r_d.sync_m = {term_proto_i, switch_bank1_i, switch_bank2_i};
		r_d.sync_s = r_q.sync_m;
		proto_t    = r_q.sync_s[16];
		bank1      = r_q.sync_s[15:8];

		// Defaults follow protocol and switches until overridden
		if (!r_q.loc_expl)
		begin
			r_d.local_set.rate = proto_t ? switch_rate(bank1)
				: RATE_115200;
		end
		if (!r_q.mod_expl)
		begin
			if (proto_t)
			begin
				r_d.modem_set.rate        = switch_rate(bank1);
				r_d.modem_set.full_duplex = bank1[SW_DUPLEX];
				r_d.modem_set.sync_mode   = bank1[SW_SYNC];
				r_d.modem_set.nrz         = bank1[SW_NRZ];
			end
			else
			begin
				r_d.modem_set.rate        = RATE_9600;
				r_d.modem_set.full_duplex = 1'b1;
				r_d.modem_set.sync_mode   = 1'b1;
				r_d.modem_set.nrz         = 1'b1;
			end
		end
		// Local line is fixed asynchronous, half duplex, NRZI
		r_d.local_set.full_duplex = 1'b0;
		r_d.local_set.sync_mode   = 1'b0;
		r_d.local_set.nrz         = 1'b0;
		both_cfg = r_q.host_cfg && r_q.nm_cfg;
		r_d.local_set.enable = both_cfg;
		r_d.modem_set.enable = both_cfg;

		// Input byte or character decode
		r_d.cmd.valid = 1'b0;
		take = host_byte_i.valid && (r_q.tx_state == TX_IDLE);
		if (take)
		begin
			ended = host_byte_i.last;
			if (!proto_t)
			begin
				got_byte = 1'b1;
				byte_val = host_byte_i.data;
			end
			else if (host_byte_i.data != ASCII_SPACE)
			begin
				hv = hex_value(host_byte_i.data);
				if (hv[4])
					r_d.bad = 1'b1;
				else if (!r_q.nib_half)
				begin
					r_d.nib_hi   = hv[3:0];
					r_d.nib_half = 1'b1;
				end
				else
				begin
					got_byte     = 1'b1;
					byte_val     = {r_q.nib_hi, hv[3:0]};
					r_d.nib_half = 1'b0;
				end
			end
			if (got_byte)
			begin
				unique case (r_q.count)
					3'd0: r_d.code = byte_val;
					3'd1: r_d.p1 = byte_val;
					3'd2: r_d.p2 = byte_val;
					default: ;
				endcase
				if (r_q.count != 3'd7)
					r_d.count = r_q.count + 3'd1;
			end
		end

		// Whole string received: check and dispatch
		if (ended)
		begin
			if (r_d.bad || r_d.nib_half || r_d.count == 3'd0)
				err = ERR_FORMAT;
			else
			begin
				unique case (r_d.code)
					CMD_CFG_HOST:
					begin
						if (r_q.host_cfg)
							err = ERR_RECONFIG;
						else
						begin
							r_d.host_cfg = 1'b1;
							if (r_d.count >= 3'd2)
								r_d.eha_mode = r_d.p1[0];
						end
					end
					CMD_CFG_NETMGR:
					begin
						if (r_q.nm_cfg)
							err = ERR_RECONFIG;
						else
						begin
							r_d.nm_cfg = 1'b1;
							if (r_d.count >= 3'd2)
							begin
								r_d.mod_expl = 1'b1;
								r_d.modem_set.rate        = r_d.p1[7:4];
								r_d.modem_set.full_duplex = r_d.p1[3];
								r_d.modem_set.sync_mode   = r_d.p1[2];
								r_d.modem_set.nrz         = r_d.p1[1];
							end
							if (r_d.count >= 3'd3)
							begin
								r_d.loc_expl = 1'b1;
								r_d.local_set.rate = r_d.p2[7:4];
							end
						end
					end
					CMD_SEND, CMD_POLL:
					begin
						if (!both_cfg)
							err = ERR_NOT_CFG;
						else if (r_d.code == CMD_POLL && !r_q.eha_mode)
							err = ERR_MODE;
						else if (r_d.count < 3'd2 || r_d.p1 == ADDR_SPECIAL
							|| r_d.p1 == ADDR_ALL)
						begin
							err = ERR_BAD_ADDR;
							with_addr = r_d.count >= 3'd2;
						end
					end
					CMD_CONNECT, CMD_DISCONNECT:
					begin
						if (!both_cfg)
							err = ERR_NOT_CFG;
						else if (r_d.count >= 3'd2 && r_d.p1 == ADDR_SPECIAL)
						begin
							err = ERR_BAD_ADDR;
							with_addr = 1'b1;
						end
					end
					CMD_BROADCAST, CMD_READ_LOG, CMD_SEC_DIAG, CMD_ADP_DIAG:
					begin
						if (!both_cfg)
							err = ERR_NOT_CFG;
					end
					default: err = ERR_BAD_CODE;
				endcase
			end
			if (err != 16'h0000)
			begin
				// Queue the error reply: code, error word, optional address
				r_d.tx_state = TX_BUSY;
				r_d.tx_buf   = {CMD_ERROR, err, r_d.p1};
				r_d.tx_len   = with_addr ? 3'd4 : 3'd3;
				r_d.tx_idx   = 3'd0;
				r_d.tx_nib   = 1'b0;
				r_d.tx_ascii = proto_t;
				r_d.last_err = err;
				ev[EV_ERROR] = 1'b1;
			end
			else
			begin
				r_d.cmd.valid = 1'b1;
				r_d.cmd.code  = r_d.code;
				r_d.cmd.addr  = r_d.p1;
				ev[EV_ACCEPT] = 1'b1;
				ev[EV_CONFIG] = r_d.host_cfg && r_d.nm_cfg && !both_cfg;
			end
			r_d.count    = 3'd0;
			r_d.bad      = 1'b0;
			r_d.nib_half = 1'b0;
		end

		// Reply sender, holds each output byte until taken
		if (r_q.resp.valid && resp_ready_i)
			r_d.resp.valid = 1'b0;
		if (r_q.tx_state == TX_BUSY && (!r_q.resp.valid || resp_ready_i))
		begin
			out_byte = r_q.tx_buf[31:24];
			r_d.resp.valid = 1'b1;
			if (r_q.tx_ascii)
			begin
				r_d.resp.data = hex_char(r_q.tx_nib ? out_byte[3:0]
					: out_byte[7:4]);
				r_d.tx_nib = !r_q.tx_nib;
			end
			else
				r_d.resp.data = out_byte;
			if (!r_q.tx_ascii || r_q.tx_nib)
			begin
				r_d.tx_buf = {r_q.tx_buf[23:0], 8'h00};
				r_d.tx_idx = r_q.tx_idx + 3'd1;
				r_d.resp.last = (r_q.tx_idx + 3'd1 == r_q.tx_len);
				if (r_q.tx_idx + 3'd1 == r_q.tx_len)
					r_d.tx_state = TX_IDLE;
			end
			else
				r_d.resp.last = 1'b0;
		end

		// Register writes: mask, and status cleared by ones with set winning
		if (reg_wr_i && reg_addr_i == REG_MASK)
			r_d.mask = reg_wdata_i[EV_W-1:0];
		if (reg_wr_i && reg_addr_i == REG_STATUS)
			r_d.status = r_q.status & ~reg_wdata_i[EV_W-1:0];
		r_d.status = r_d.status | ev;

		// Register reads, unmapped offsets read zero
		r_d.rdata = 32'h0000_0000;
		if (reg_rd_i)
		begin
			unique case (reg_addr_i)
				REG_STATUS: r_d.rdata = {29'h0, r_q.status};
				REG_MASK:   r_d.rdata = {29'h0, r_q.mask};
				REG_STATE:  r_d.rdata = {r_q.last_err, 12'h000,
					proto_t, r_q.eha_mode, r_q.nm_cfg, r_q.host_cfg};
				REG_PORTS:  r_d.rdata = {16'h0000, r_q.modem_set,
					r_q.local_set};
				default:    r_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	// State register
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			r_q <= '0;
		else
			r_q <= r_d;
	end

	// Outputs
	assign host_ready_o    = (r_q.tx_state == TX_IDLE);
	assign resp_byte_o     = r_q.resp;
	assign cmd_o           = r_q.cmd;
	assign local_port_o    = r_q.local_set;
	assign modem_port_o    = r_q.modem_set;
	assign host_port_cfg_o = r_q.sync_s[15:0]; // Both banks
	assign reg_rdata_o     = r_q.rdata;
	assign irq_o           = |(r_q.status & r_q.mask);

endmodule // host_command_front_end

// *** hw/host_front_pkg.sv ***
// Purpose: Shared constants and types of the host command front end.
// Assumes: One clock; bytes from the host receiver arrive on that clock.
// Notes:   Bit 7 of every host byte is its most significant bit.
package host_front_pkg;

	// Register offsets and interrupt bits
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_MASK   = 8'h04;
	localparam logic [7:0] REG_STATE  = 8'h08;
	localparam logic [7:0] REG_PORTS  = 8'h0C;
	localparam int         EV_ACCEPT  = 0;
	localparam int         EV_ERROR   = 1;
	localparam int         EV_CONFIG  = 2;
	localparam int         EV_W       = 3;

	// Command codes
	localparam logic [7:0] CMD_ERROR      = 8'h00;
	localparam logic [7:0] CMD_SEND       = 8'h01;
	localparam logic [7:0] CMD_BROADCAST  = 8'h02;
	localparam logic [7:0] CMD_POLL       = 8'h03;
	localparam logic [7:0] CMD_CONNECT    = 8'h04;
	localparam logic [7:0] CMD_DISCONNECT = 8'h05;
	localparam logic [7:0] CMD_READ_LOG   = 8'h06;
	localparam logic [7:0] CMD_SEC_DIAG   = 8'h07;
	localparam logic [7:0] CMD_ADP_DIAG   = 8'h08;
	localparam logic [7:0] CMD_CFG_HOST   = 8'h40;
	localparam logic [7:0] CMD_CFG_NETMGR = 8'h41;

	// Reserved secondary addresses
	localparam logic [7:0] ADDR_SPECIAL = 8'h00;
	localparam logic [7:0] ADDR_ALL     = 8'hFF;

	// Error codes
	localparam logic [15:0] ERR_FORMAT   = 16'h0001;
	localparam logic [15:0] ERR_BAD_CODE = 16'h0002;
	localparam logic [15:0] ERR_RECONFIG = 16'h0003;
	localparam logic [15:0] ERR_NOT_CFG  = 16'h0004;
	localparam logic [15:0] ERR_BAD_ADDR = 16'h0005;
	localparam logic [15:0] ERR_MODE     = 16'h0006;

	// Rate codes: 4 is 110 baud up to F at 115200 baud
	localparam logic [3:0] RATE_MIN    = 4'h4;
	localparam logic [3:0] RATE_9600   = 4'hB;
	localparam logic [3:0] RATE_115200 = 4'hF;

	// Switch positions, index is position minus one
	localparam int SW_DUPLEX = 1;
	localparam int SW_SYNC   = 2;
	localparam int SW_NRZ    = 3;
	localparam int SW_RATE_3 = 4;
	localparam int SW_RATE_2 = 5;
	localparam int SW_RATE_1 = 6;
	localparam int SW_RATE_0 = 7;

	// Characters of the terminal protocol
	localparam logic [7:0] ASCII_SPACE = 8'h20;
	localparam logic [7:0] ASCII_ZERO  = 8'h30;
	localparam logic [7:0] ASCII_NINE  = 8'h39;
	localparam logic [7:0] ASCII_UP_A  = 8'h41;
	localparam logic [7:0] ASCII_UP_F  = 8'h46;
	localparam logic [7:0] ASCII_LO_A  = 8'h61;
	localparam logic [7:0] ASCII_LO_F  = 8'h66;
	localparam logic [7:0] ASCII_HEX10 = 8'h0A;

	typedef struct packed {
		logic       enable;
		logic [3:0] rate;
		logic       full_duplex;
		logic       sync_mode;
		logic       nrz;
	} port_setting_type;

	typedef struct packed {
		logic       valid;
		logic       last;
		logic [7:0] data;
	} stream_byte_type;

	typedef struct packed {
		logic       valid;
		logic [7:0] code;
		logic [7:0] addr;
	} cmd_type;

	typedef enum logic {TX_IDLE, TX_BUSY} tx_state_type;

endpackage

// *** verification/front_end_asserts.sv ***
// Purpose: Port assertions of the host command front end.
// Assumes: One clock domain; reset is asynchronous and active low.
// Notes:   Bound to every instance of the front end.
`timescale 1ns/10ps
module front_end_checker
	import host_front_pkg::*;
(
	input wire logic             mclk_i,
	input wire logic             reset_n_i,
	input wire stream_byte_type  host_byte_i,
	input wire logic             host_ready_o,
	input wire stream_byte_type  resp_byte_o,
	input wire logic             resp_ready_i,
	input wire cmd_type          cmd_o,
	input wire port_setting_type local_port_o,
	input wire port_setting_type modem_port_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!reset_n_i);

	// Final unit of a string taken, then the refusal that follows it
	sequence s_taken;
		host_byte_i.valid && host_byte_i.last && host_ready_o;
	endsequence
	sequence s_refused;
		s_taken ##1 !host_ready_o;
	endsequence

	// Port settings and command handling
	AST_LOCAL_FIXED: assert property (!local_port_o.full_duplex &&
		!local_port_o.sync_mode && !local_port_o.nrz)
		else $error("local port not async half NRZI");
	AST_SAME_ENABLE: assert property (local_port_o.enable ==
		modem_port_o.enable) else $error("ports enabled apart");
	AST_RATE_RANGE: assert property (local_port_o.enable |->
		local_port_o.rate >= RATE_MIN && modem_port_o.rate >= RATE_MIN)
		else $error("rate code out of range");
	AST_CMD_CAUSE: assert property (cmd_o.valid |->
		$past(host_byte_i.valid && host_byte_i.last && host_ready_o))
		else $error("command without a string");
	AST_TAKEN_ANSWER: assert property (s_taken |=>
		cmd_o.valid || !host_ready_o) else $error("string not answered");
	AST_ERR_OPEN: assert property (s_refused |=> resp_byte_o.valid &&
		(resp_byte_o.data == CMD_ERROR || resp_byte_o.data == ASCII_ZERO))
		else $error("error reply did not open with 00");
	AST_RESP_HOLD: assert property (resp_byte_o.valid && !resp_ready_i
		|=> resp_byte_o.valid && $stable(resp_byte_o))
		else $error("reply unit dropped before taken");
	AST_REPLY_END: assert property (resp_byte_o.valid &&
		resp_byte_o.last && resp_ready_i |-> ##[0:1] host_ready_o)
		else $error("input not reopened after reply");
endmodule // front_end_checker

bind host_command_front_end front_end_checker u_chk
(
	.mclk_i       (mclk_i),
	.reset_n_i    (reset_n_i),
	.host_byte_i  (host_byte_i),
	.host_ready_o (host_ready_o),
	.resp_byte_o  (resp_byte_o),
	.resp_ready_i (resp_ready_i),
	.cmd_o        (cmd_o),
	.local_port_o (local_port_o),
	.modem_port_o (modem_port_o)
);

// *** verification/host_model.sv ***
// Purpose: Host computer on the serial host port.
// Assumes: Strings are queued by the bench through put or pushed straight onto txq.
// Notes:   A released data line shows the inverse of its last value.
`timescale 1ns/10ps
module host_model
	import host_front_pkg::*;
(
	input  wire logic            mclk_i,
	input  wire logic            term_i,
	input  wire logic            slow_i,
	input  wire logic            host_ready_i,
	input  wire stream_byte_type resp_byte_i,
	output stream_byte_type      host_byte_o,
	output logic                 resp_ready_o
);
	logic [8:0] txq[$];
	logic [8:0] rxq[$];
	logic [8:0] w;

	function automatic logic [7:0] hexc(input logic [3:0] n);
		return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
	endfunction

	// Queues a byte, as two hex characters high nibble first if terminal
	task put(input logic [7:0] b, input logic last);
		if (term_i)
		begin
			txq.push_back({1'b0, hexc(b[7:4])});
			txq.push_back({last, hexc(b[3:0])});
		end
		else
			txq.push_back({last, b});
	endtask

	initial
	begin
		host_byte_o = '0;
		resp_ready_o = 1'b1;
	end

	// Presents queued units and holds each until the edge that takes it
	always @(posedge mclk_i)
		if (!host_byte_o.valid || host_ready_i)
		begin
			if (txq.size() != 0)
			begin
				w = txq.pop_front();
				host_byte_o <= '{1'b1, w[8], w[7:0]};
			end
			else
				host_byte_o <= '{1'b0, 1'b0, ~host_byte_o.data};
		end

	// Collects reply units; stalls every other cycle when slow
	always @(posedge mclk_i)
	begin
		if (resp_byte_i.valid && resp_ready_o)
			rxq.push_back({resp_byte_i.last, resp_byte_i.data});
		resp_ready_o <= slow_i ? ~resp_ready_o : 1'b1;
	end
endmodule // host_model

// *** verification/testbench.sv ***
// Purpose: Self-checking bench of the host command front end.
// Assumes: 250 MHz clock; registers on the plain strobe port.
// Notes:   Switch rows first, then command strings in both protocols.
`timescale 1ns/10ps
module testbench;
	import host_front_pkg::*;
	typedef struct packed {
		logic       term;
		logic [7:0] sw;
		logic [7:0] modem;
		logic [7:0] loc;
	} row_type;
	row_type rows[6] = '{'{1'b1, 8'h2A, 8'h25, 8'h20},
		'{1'b1, 8'hF4, 8'h7A, 8'h78}, '{1'b1, 8'h80, 8'h58, 8'h58},
		'{1'b1, 8'hDF, 8'h5F, 8'h58}, '{1'b1, 8'h60, 8'h30, 8'h30},
		'{1'b0, 8'hF1, 8'h5F, 8'h78}};
	logic             mclk_i = 1'b0;
	logic             reset_n_i = 1'b0;
	logic             term_proto_i = 1'b0;
	logic [7:0]       switch_bank1_i = 8'h00;
	logic [7:0]       switch_bank2_i = 8'h00;
	logic [7:0]       reg_addr_i = 8'h00;
	logic [31:0]      reg_wdata_i = 32'h0;
	logic             reg_wr_i = 1'b0;
	logic             reg_rd_i = 1'b0;
	logic             slow = 1'b0;
	stream_byte_type  host_byte_i;
	stream_byte_type  resp_byte_o;
	logic             host_ready_o;
	logic             resp_ready_i;
	cmd_type          cmd_o;
	port_setting_type local_port_o;
	port_setting_type modem_port_o;
	logic [15:0]      host_port_cfg_o;
	logic [31:0]      reg_rdata_o;
	logic             irq_o;
	logic [15:0]      cmdq[$];
	logic [15:0]      got;
	int               fail_count = 0;
	int               checks_done = 0;

	always #2 mclk_i = ~mclk_i;

	host_model host (.mclk_i(mclk_i), .term_i(term_proto_i), .slow_i(slow),
		.host_ready_i(host_ready_o), .resp_byte_i(resp_byte_o),
		.host_byte_o(host_byte_i), .resp_ready_o(resp_ready_i));

	host_command_front_end uut (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
		.term_proto_i(term_proto_i), .switch_bank1_i(switch_bank1_i),
		.switch_bank2_i(switch_bank2_i), .host_byte_i(host_byte_i),
		.host_ready_o(host_ready_o), .resp_byte_o(resp_byte_o),
		.resp_ready_i(resp_ready_i), .cmd_o(cmd_o),
		.local_port_o(local_port_o), .modem_port_o(modem_port_o),
		.host_port_cfg_o(host_port_cfg_o), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));

	// Records every command handed on
	always @(posedge mclk_i)
		if (cmd_o.valid === 1'b1)
			cmdq.push_back({cmd_o.code, cmd_o.addr});

	task check(input string nm, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task give_verdict();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task do_reset(input logic t);
		reset_n_i <= 1'b0;
		term_proto_i <= t;
		repeat (16) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
	endtask

	task settle();
		repeat (2) @(posedge mclk_i);
		@(negedge mclk_i);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		@(negedge mclk_i);
		check("reg_rdata_o", reg_rdata_o, e);
	endtask

	// Waits for a whole reply and compares it unit by unit
	task reply(input logic [31:0] v, input int n);
		logic [7:0] b;
		logic [7:0] ch;
		logic [3:0] n4;
		int         k;
		k = term_proto_i ? 2 * n : n;
		for (int j = 0; j < 300 && host.rxq.size() < k; j++)
			@(posedge mclk_i);
		for (int j = 0; j < k; j++)
		begin
			b = v[31 - 8 * (term_proto_i ? j / 2 : j) -: 8];
			n4 = (term_proto_i && j % 2 == 0) ? b[7:4] : b[3:0];
			ch = n4 < 4'hA ? 8'h30 + 8'(n4) : 8'h37 + 8'(n4);
			ch = term_proto_i ? ch : b;
			check("reply", host.rxq.size() ? host.rxq.pop_front() : 'x,
				{j == k - 1, ch});
		end
	endtask

	// Waits for the next command handed on, unknown if none comes
	task get_cmd(output logic [15:0] c);
		for (int j = 0; j < 300 && cmdq.size() == 0; j++)
			@(posedge mclk_i);
		c = cmdq.size() ? cmdq.pop_front() : 'x;
	endtask

	// Sends code and one parameter; n zero means a command is expected
	task send2(input logic [7:0] c, a, input logic [31:0] v, input int n);
		host.put(c, 1'b0);
		host.put(a, 1'b1);
		if (n == 0)
		begin
			get_cmd(got);
			check("cmd_o", got, {c, a});
		end
		else
			reply(v, n);
	endtask

	// Main sequence
	initial
	begin
		foreach (rows[r])
		begin
			switch_bank1_i <= rows[r].sw;
			switch_bank2_i <= ~rows[r].sw;
			do_reset(rows[r].term);
			@(negedge mclk_i);
			check("modem", modem_port_o, rows[r].modem);
			check("local", local_port_o, rows[r].loc);
			check("host_cfg", host_port_cfg_o, {rows[r].sw, ~rows[r].sw});
		end
		rd(REG_STATUS, 32'h0);
		slow <= 1'b1;
		send2(CMD_SEND, 8'h05, 32'h0000_0400, 3);
		slow <= 1'b0;
		rd(REG_STATUS, 32'h2);
		wr(REG_MASK, 32'h2);
		settle();
		check("irq_o", irq_o, 1'b1);
		wr(REG_STATUS, 32'h2);
		settle();
		check("irq_o", irq_o, 1'b0);
		send2(8'h3F, 8'h00, 32'h0000_0200, 3);
		send2(CMD_CFG_HOST, 8'h01, 0, 0);
		send2(CMD_CFG_HOST, 8'h00, 32'h0000_0300, 3);
		rd(REG_STATE, 32'h0003_0005);
		check("enable", local_port_o.enable, 1'b0);
		wr(REG_MASK, 32'h4);
		host.put(CMD_CFG_NETMGR, 1'b0);
		host.put(8'h74, 1'b0);
		host.put(8'h90, 1'b1);
		get_cmd(got);
		check("cmd_o", got, {CMD_CFG_NETMGR, 8'h74});
		settle();
		check("modem", modem_port_o, 8'hBA);
		check("local", local_port_o, 8'hC8);
		check("irq_o", irq_o, 1'b1);
		rd(REG_PORTS, 32'h0000_BAC8);
		rd(8'h10, 32'h0);
		send2(CMD_SEND, ADDR_SPECIAL, 32'h0000_0500, 4);
		send2(CMD_POLL, ADDR_ALL, 32'h0000_05FF, 4);
		send2(CMD_SEND, 8'hFE, 0, 0);
		send2(CMD_CONNECT, ADDR_ALL, 0, 0);
		do_reset(1'b1);
		send2(CMD_CFG_HOST, 8'h00, 0, 0);
		send2(CMD_SEND, 8'h05, 32'h0000_0400, 3);
		host.txq.push_back({1'b1, 8'h47});
		reply(32'h0000_0100, 3);
		host.txq.push_back({1'b1, 8'h34});
		reply(32'h0000_0100, 3);
		// Network manager set with no parameters, closed by a space
		host.txq.push_back({1'b0, 8'h34});
		host.txq.push_back({1'b0, 8'h31});
		host.txq.push_back({1'b1, ASCII_SPACE});
		get_cmd(got);
		check("cmd_code", got[15:8], CMD_CFG_NETMGR);
		send2(CMD_POLL, 8'h05, 32'h0000_0600, 3);
		check("modem", modem_port_o, 8'hF8);
		check("local", local_port_o, 8'hF8);
		send2(CMD_DISCONNECT, ADDR_SPECIAL, 32'h0000_0500, 4);
		give_verdict();
	end

	// Cuts a hang short
	initial
	begin
		repeat (20000) @(posedge mclk_i);
		fail_count++;
		give_verdict();
	end
endmodule // testbench
